// ### hdl/pe_dev.sv
// Purpose: Eight-bit muxed port with bus, slave strobes and capture pin
// Assumes: Pins sampled synchronously; one AXI write and read at a time
// Notes:   OTHER_RST is the non power-on reset, synchronous
`timescale 1ns/1ps
`include "pe_defs.svh"
module pe_dev #(
  parameter int AW = 8
) (
  input  logic          CLK,
  input  logic          NRST,
  input  logic          CE,
  input  logic          OTHER_RST,
  input  logic [1:0]    MODE,
  input  logic          LARGE_PKG,
  input  logic          CAP_PIN_SEL,
  input  logic [7:0]    EBUS_OUT_HI,
  input  logic [7:0]    EBUS_OUT_LO,
  input  logic          EBUS_OE,
  output logic [7:0]    EBUS_IN_HI,
  output logic [7:0]    EBUS_IN_LO,
  input  logic          CCP_OUT,
  input  logic          CCP_OE,
  output logic          CCP_IN,
  input  logic [AW-1:0] AWADDR,
  input  logic          AWVALID,
  output logic          AWREADY,
  input  logic [31:0]   WDATA,
  input  logic [3:0]    WSTRB,
  input  logic          WVALID,
  output logic          WREADY,
  output logic [1:0]    BRESP,
  output logic          BVALID,
  input  logic          BREADY,
  input  logic [AW-1:0] ARADDR,
  input  logic          ARVALID,
  output logic          ARREADY,
  output logic [31:0]   RDATA,
  output logic [1:0]    RRESP,
  output logic          RVALID,
  input  logic          RREADY,
  pe_pin_if.dev         P
);
  if (AW < 5) begin : g_chk
    $error("AW too narrow for register map");
  end

  function automatic logic is_reg(input logic [AW-1:0] a, input logic [7:0] o);
    return a == AW'(o);
  endfunction

  function automatic logic mapped(input logic [AW-1:0] a);
    return is_reg(a, `PE_OFS_DIR) || is_reg(a, `PE_OFS_PIN) || is_reg(a, `PE_OFS_LAT)
        || is_reg(a, `PE_OFS_MEM) || is_reg(a, `PE_OFS_SPC) || is_reg(a, `PE_OFS_SPD);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]    dir_ff, nxt_dir, lat_ff, nxt_lat, mem_ff, nxt_mem;
  logic [7:0]    spc_ff, nxt_spc, sdin_ff, nxt_sdin, sdout_ff, nxt_sdout;
  logic [7:0]    wcap_ff, nxt_wcap;
  logic          rd_act_ff, nxt_rd_act, wr_act_ff, nxt_wr_act;
  logic          aw_free_ff, nxt_aw_free, w_free_ff, nxt_w_free;
  logic          ar_free_ff, nxt_ar_free, bvalid_ff, nxt_bvalid;
  logic          rvalid_ff, nxt_rvalid, wstb_ff, nxt_wstb;
  logic [AW-1:0] awaddr_ff, nxt_awaddr;
  logic [7:0]    wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
  logic [1:0]    bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [7:0]    pin_ff, dpin_ff;
  logic [7:0]    out_ff, nxt_out, oe_n_ff, nxt_oe_n, dout_ff, nxt_dout;
  logic [7:0]    doe_n_ff, nxt_doe_n;
  logic          mc, bus_act, psp_act, ccp_alt, cs, rd, wr;

  assign mc      = MODE == pe_pkg::PE_MC;
  assign bus_act = LARGE_PKG && !mc && !mem_ff[`PE_MEM_BUSDIS];
  assign psp_act = mc && spc_ff[`PE_SPC_EN];
  assign ccp_alt = mc && LARGE_PKG && !CAP_PIN_SEL;
  assign cs      = !pin_ff[2];
  assign rd      = psp_act && cs && !pin_ff[0];
  assign wr      = psp_act && cs && !pin_ff[1];

  ////////////////////////////////////////////////////////////////////////////
  // Registers, slave strobes and AXI
  always_comb begin
    nxt_dir     = dir_ff;
    nxt_lat     = lat_ff;
    nxt_mem     = mem_ff;
    nxt_spc     = spc_ff;
    nxt_sdin    = sdin_ff;
    nxt_sdout   = sdout_ff;
    nxt_wcap    = wcap_ff;
    nxt_rd_act  = rd;
    nxt_wr_act  = wr;
    nxt_aw_free = aw_free_ff;
    nxt_w_free  = w_free_ff;
    nxt_ar_free = ar_free_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_rvalid  = rvalid_ff;
    nxt_awaddr  = awaddr_ff;
    nxt_wdata   = wdata_ff;
    nxt_wstb    = wstb_ff;
    nxt_rdata   = rdata_ff;
    nxt_bresp   = bresp_ff;
    nxt_rresp   = rresp_ff;
    if (AWVALID && aw_free_ff) begin
      nxt_awaddr  = AWADDR;
      nxt_aw_free = 1'b0;
    end
    if (WVALID && w_free_ff) begin
      nxt_wdata  = WDATA[7:0];
      nxt_wstb   = WSTRB[0];
      nxt_w_free = 1'b0;
    end
    if (bvalid_ff && BREADY) begin
      nxt_bvalid = 1'b0;
    end
    if (rd_act_ff && !rd) begin
      nxt_spc[`PE_SPC_OBF] = 1'b0;
    end
    // Address and data may arrive in either order
    if (!aw_free_ff && !w_free_ff && !bvalid_ff) begin
      nxt_aw_free = 1'b1;
      nxt_w_free  = 1'b1;
      nxt_bvalid  = 1'b1;
      nxt_bresp   = mapped(awaddr_ff) ? `PE_RESP_OKAY : `PE_RESP_SLVERR;
      if (wstb_ff) begin
        if (is_reg(awaddr_ff, `PE_OFS_DIR)) begin
          nxt_dir = wdata_ff;
        end else if (is_reg(awaddr_ff, `PE_OFS_PIN) || is_reg(awaddr_ff, `PE_OFS_LAT)) begin
          nxt_lat = wdata_ff;
        end else if (is_reg(awaddr_ff, `PE_OFS_MEM)) begin
          nxt_mem = wdata_ff & `PE_MEM_MASK;
        end else if (is_reg(awaddr_ff, `PE_OFS_SPC)) begin
          nxt_spc[`PE_SPC_EN]   = wdata_ff[`PE_SPC_EN];
          nxt_spc[`PE_SPC_IBOV] = spc_ff[`PE_SPC_IBOV] & wdata_ff[`PE_SPC_IBOV];
        end else if (is_reg(awaddr_ff, `PE_OFS_SPD)) begin
          nxt_sdout             = wdata_ff;
          nxt_spc[`PE_SPC_OBF]  = 1'b1;
        end
      end
    end
    if (rvalid_ff && RREADY) begin
      nxt_rvalid  = 1'b0;
      nxt_ar_free = 1'b1;
    end
    if (ARVALID && ar_free_ff) begin
      nxt_ar_free = 1'b0;
      nxt_rvalid  = 1'b1;
      nxt_rresp   = mapped(ARADDR) ? `PE_RESP_OKAY : `PE_RESP_SLVERR;
      nxt_rdata   = 8'h00;
      if (is_reg(ARADDR, `PE_OFS_DIR)) begin
        nxt_rdata = dir_ff;
      end else if (is_reg(ARADDR, `PE_OFS_PIN)) begin
        nxt_rdata = pin_ff;
      end else if (is_reg(ARADDR, `PE_OFS_LAT)) begin
        nxt_rdata = lat_ff;
      end else if (is_reg(ARADDR, `PE_OFS_MEM)) begin
        nxt_rdata = mem_ff;
      end else if (is_reg(ARADDR, `PE_OFS_SPC)) begin
        nxt_rdata = spc_ff;
      end else if (is_reg(ARADDR, `PE_OFS_SPD)) begin
        nxt_rdata            = sdin_ff;
        nxt_spc[`PE_SPC_IBF] = 1'b0;
      end
    end
    // Host write events follow the AXI updates so a set beats a same-cycle AXI clear
    if (wr) begin
      nxt_wcap = dpin_ff;
    end
    if (wr_act_ff && !wr) begin
      nxt_sdin = wcap_ff;
      if (spc_ff[`PE_SPC_IBF]) begin
        nxt_spc[`PE_SPC_IBOV] = 1'b1;
      end
      nxt_spc[`PE_SPC_IBF] = 1'b1;
    end
    // Latch kept: only power-on clears it
    if (OTHER_RST) begin
      nxt_dir = `PE_DIR_RST;
      nxt_mem = `PE_MEM_RST;
      nxt_spc = `PE_SPC_RST;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      dir_ff     <= `PE_DIR_RST;
      lat_ff     <= `PE_LAT_RST;
      mem_ff     <= `PE_MEM_RST;
      spc_ff     <= `PE_SPC_RST;
      sdin_ff    <= 8'h00;
      sdout_ff   <= 8'h00;
      wcap_ff    <= 8'h00;
      rd_act_ff  <= 1'b0;
      wr_act_ff  <= 1'b0;
      aw_free_ff <= 1'b1;
      w_free_ff  <= 1'b1;
      ar_free_ff <= 1'b1;
      bvalid_ff  <= 1'b0;
      rvalid_ff  <= 1'b0;
      awaddr_ff  <= '0;
      wdata_ff   <= 8'h00;
      wstb_ff    <= 1'b0;
      rdata_ff   <= 8'h00;
      bresp_ff   <= `PE_RESP_OKAY;
      rresp_ff   <= `PE_RESP_OKAY;
    end else if (CE) begin
      dir_ff     <= nxt_dir;
      lat_ff     <= nxt_lat;
      mem_ff     <= nxt_mem;
      spc_ff     <= nxt_spc;
      sdin_ff    <= nxt_sdin;
      sdout_ff   <= nxt_sdout;
      wcap_ff    <= nxt_wcap;
      rd_act_ff  <= nxt_rd_act;
      wr_act_ff  <= nxt_wr_act;
      aw_free_ff <= nxt_aw_free;
      w_free_ff  <= nxt_w_free;
      ar_free_ff <= nxt_ar_free;
      bvalid_ff  <= nxt_bvalid;
      rvalid_ff  <= nxt_rvalid;
      awaddr_ff  <= nxt_awaddr;
      wdata_ff   <= nxt_wdata;
      wstb_ff    <= nxt_wstb;
      rdata_ff   <= nxt_rdata;
      bresp_ff   <= nxt_bresp;
      rresp_ff   <= nxt_rresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive and sampling
  always_comb begin
    nxt_out   = lat_ff;
    nxt_oe_n  = dir_ff;
    nxt_dout  = sdout_ff;
    nxt_doe_n = 8'hFF;
    if (psp_act) begin
      nxt_oe_n[2:0] = 3'h7;
    end
    if (ccp_alt) begin
      nxt_out[7]  = CCP_OUT;
      nxt_oe_n[7] = !CCP_OE;
    end
    if (bus_act) begin
      nxt_out   = EBUS_OUT_HI;
      nxt_oe_n  = {8{!EBUS_OE}};
      nxt_dout  = EBUS_OUT_LO;
      nxt_doe_n = {8{!EBUS_OE}};
    end else if (rd) begin
      nxt_doe_n = 8'h00;
    end
  end

  // Single sample suffices: pins are synchronous to CLK
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      out_ff   <= `PE_LAT_RST;
      oe_n_ff  <= 8'hFF;
      dout_ff  <= 8'h00;
      doe_n_ff <= 8'hFF;
      pin_ff   <= 8'hFF;
      dpin_ff  <= 8'hFF;
    end else if (CE) begin
      out_ff   <= nxt_out;
      oe_n_ff  <= nxt_oe_n;
      dout_ff  <= nxt_dout;
      doe_n_ff <= nxt_doe_n;
      pin_ff   <= P.pin;
      dpin_ff  <= P.dpin;
    end
  end

  assign P.dev_out    = out_ff;
  assign P.dev_oe_n   = oe_n_ff;
  assign P.dev_d_out  = dout_ff;
  assign P.dev_d_oe_n = doe_n_ff;
  assign EBUS_IN_HI   = pin_ff;
  assign EBUS_IN_LO   = dpin_ff;
  assign CCP_IN       = pin_ff[7];
  assign AWREADY      = aw_free_ff;
  assign WREADY       = w_free_ff;
  assign BVALID       = bvalid_ff;
  assign BRESP        = bresp_ff;
  assign ARREADY      = ar_free_ff;
  assign RVALID       = rvalid_ff;
  assign RRESP        = rresp_ff;
  assign RDATA        = {24'h000000, rdata_ff};
endmodule

// ### hdl/pe_defs.svh
// Purpose: Constants for the muxed port and its parallel slave link
// Assumes: 250 MHz core clock, 32-bit AXI4-Lite register access
// Notes:   Offsets are byte addresses, one aligned word per register
//
// How it works
// - Direction one makes the pin an input
// - Direction zero drives the output latch value
// - Latch reads return latch, not pins
// - Eight pins, each with own direction bit
// - Port I/O only while bus disabled
// - Processor/extended modes on large package: pins carry address/data high byte
// - Slave enable in microcontroller mode turns pins 2:0 into strobes
// - Software sets pins 2:0 as inputs first; the code forces them to inputs itself while the slave port is active
// - Select bit clear in microcontroller mode on large package routes capture unit to pin 7
// - Extended mode on large package starts as bus
// - Read strobe low with select returns slave data
// - Write strobe low with select loads slave data
// - Pin 2 is active-low chip select
// - Pins 0-7 double as address/data bits 8-15
// - Low byte travels on companion eight-bit port
`ifndef PE_DEFS_SVH
`define PE_DEFS_SVH
`define PE_OFS_DIR     8'h00
`define PE_OFS_PIN     8'h04
`define PE_OFS_LAT     8'h08
`define PE_OFS_MEM     8'h0C
`define PE_OFS_SPC     8'h10
`define PE_OFS_SPD     8'h14
`define PE_HOFS_CMD    8'h00
`define PE_HOFS_STAT   8'h04
`define PE_MEM_BUSDIS  7
`define PE_MEM_MASK    8'hB3
`define PE_SPC_IBF     7
`define PE_SPC_OBF     6
`define PE_SPC_IBOV    5
`define PE_SPC_EN      4
`define PE_DIR_RST     8'hFF
`define PE_LAT_RST     8'h00
`define PE_MEM_RST     8'h00
`define PE_SPC_RST     8'h00
`define PE_RESP_OKAY   2'h0
`define PE_RESP_SLVERR 2'h2
`define PE_CLK_MHZ     250
`define PE_STROBE_NS   40
`define PE_SETUP_NS    8
`define PE_STROBE_CYC  ((`PE_STROBE_NS * `PE_CLK_MHZ + 999) / 1000)
`define PE_SETUP_CYC   ((`PE_SETUP_NS * `PE_CLK_MHZ + 999) / 1000)
`endif

// ### hdl/pe_pkg.sv
// Purpose: Types shared by both ends of the port link
// Assumes: Nothing
// Notes:   Constants live in pe_defs.svh
package pe_pkg;
  typedef enum logic [1:0] {
    PE_MC  = 2'h0,
    PE_EXT = 2'h1,
    PE_MP  = 2'h2
  } pe_mode_e;
  typedef enum logic [1:0] {
    PE_H_IDLE  = 2'h0,
    PE_H_SETUP = 2'h1,
    PE_H_STRB  = 2'h3,
    PE_H_HOLD  = 2'h2
  } pe_hst_e;
endpackage

// ### hdl/pe_pin_if.sv
// Purpose: Shared pins between the port and the outside host
// Assumes: Pull-ups on every pin; oe_n low means driving
// Notes:   Wired-AND resolution, a clash reads as zero
`timescale 1ns/1ps
interface pe_pin_if;
  logic [7:0] dev_out;
  logic [7:0] dev_oe_n;
  logic [7:0] host_out;
  logic [7:0] host_oe_n;
  logic [7:0] dev_d_out;
  logic [7:0] dev_d_oe_n;
  logic [7:0] host_d_out;
  logic [7:0] host_d_oe_n;
  logic [7:0] pin;
  logic [7:0] dpin;
  assign pin  = (dev_out | dev_oe_n) & (host_out | host_oe_n);
  assign dpin = (dev_d_out | dev_d_oe_n) & (host_d_out | host_d_oe_n);
  modport dev  (output dev_out, dev_oe_n, dev_d_out, dev_d_oe_n, input pin, dpin);
  modport host (output host_out, host_oe_n, host_d_out, host_d_oe_n, input pin, dpin);
endinterface

// ### hdl/pe_host.sv
// Purpose: Outside host that runs slave-port reads and writes
// Assumes: Device end has its slave port enabled and pins 2:0 as inputs
// Notes:   One transfer at a time; commands while busy are dropped
`timescale 1ns/1ps
`include "pe_defs.svh"
module pe_host #(
  parameter int AW         = 8,
  parameter int STROBE_CYC = `PE_STROBE_CYC,
  parameter int SETUP_CYC  = `PE_SETUP_CYC
) (
  input  logic          CLK,
  input  logic          NRST,
  input  logic          CE,
  input  logic [AW-1:0] AWADDR,
  input  logic          AWVALID,
  output logic          AWREADY,
  input  logic [31:0]   WDATA,
  input  logic [3:0]    WSTRB,
  input  logic          WVALID,
  output logic          WREADY,
  output logic [1:0]    BRESP,
  output logic          BVALID,
  input  logic          BREADY,
  input  logic [AW-1:0] ARADDR,
  input  logic          ARVALID,
  output logic          ARREADY,
  output logic [31:0]   RDATA,
  output logic [1:0]    RRESP,
  output logic          RVALID,
  input  logic          RREADY,
  pe_pin_if.host        P
);
  if (AW < 3 || STROBE_CYC < 3 || STROBE_CYC > 255 || SETUP_CYC < 1 || SETUP_CYC > 255)
  begin : g_chk
    $error("Unsupported host parameters");
  end

  ////////////////////////////////////////////////////////////////////////////
  pe_pkg::pe_hst_e st_ff, nxt_st;
  logic [7:0]    cnt_ff, nxt_cnt, wd_ff, nxt_wd, rd_ff, nxt_rd;
  logic          is_wr_ff, nxt_is_wr;
  logic [2:0]    strb_ff, nxt_strb;
  logic          aw_free_ff, nxt_aw_free, w_free_ff, nxt_w_free, bvalid_ff, nxt_bvalid;
  logic          ar_free_ff, nxt_ar_free, rvalid_ff, nxt_rvalid;
  logic [AW-1:0] awaddr_ff, nxt_awaddr;
  logic [15:0]   wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
  logic [1:0]    bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic          cmd_hit;

  assign cmd_hit = awaddr_ff == AW'(`PE_HOFS_CMD);

  always_comb begin
    nxt_st      = st_ff;
    nxt_cnt     = cnt_ff;
    nxt_wd      = wd_ff;
    nxt_rd      = rd_ff;
    nxt_is_wr   = is_wr_ff;
    nxt_strb    = strb_ff;
    nxt_aw_free = aw_free_ff;
    nxt_w_free  = w_free_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_ar_free = ar_free_ff;
    nxt_rvalid  = rvalid_ff;
    nxt_awaddr  = awaddr_ff;
    nxt_wdata   = wdata_ff;
    nxt_rdata   = rdata_ff;
    nxt_bresp   = bresp_ff;
    nxt_rresp   = rresp_ff;
    if (AWVALID && aw_free_ff) begin
      nxt_awaddr  = AWADDR;
      nxt_aw_free = 1'b0;
    end
    if (WVALID && w_free_ff) begin
      nxt_wdata  = WSTRB[1:0] == 2'h3 ? WDATA[15:0] : 16'h0000;
      nxt_w_free = 1'b0;
    end
    if (bvalid_ff && BREADY) begin
      nxt_bvalid = 1'b0;
    end
    if (rvalid_ff && RREADY) begin
      nxt_rvalid  = 1'b0;
      nxt_ar_free = 1'b1;
    end
    if (ARVALID && ar_free_ff) begin
      nxt_ar_free = 1'b0;
      nxt_rvalid  = 1'b1;
      nxt_rresp   = `PE_RESP_OKAY;
      nxt_rdata   = 16'h0000;
      if (ARADDR == AW'(`PE_HOFS_STAT)) begin
        nxt_rdata = {rd_ff, 7'h00, st_ff != pe_pkg::PE_H_IDLE};
      end else if (ARADDR != AW'(`PE_HOFS_CMD)) begin
        nxt_rresp = `PE_RESP_SLVERR;
      end
    end
    case (st_ff)
      pe_pkg::PE_H_IDLE: begin
        nxt_strb = 3'h7;
      end
      pe_pkg::PE_H_SETUP: begin
        nxt_cnt = cnt_ff - 8'h01;
        if (cnt_ff == 8'h00) begin
          nxt_st   = pe_pkg::PE_H_STRB;
          nxt_cnt  = 8'(STROBE_CYC - 1);
          nxt_strb = is_wr_ff ? 3'h1 : 3'h2;
        end
      end
      pe_pkg::PE_H_STRB: begin
        nxt_cnt = cnt_ff - 8'h01;
        if (cnt_ff == 8'h00) begin
          nxt_st   = pe_pkg::PE_H_HOLD;
          nxt_cnt  = 8'(SETUP_CYC - 1);
          nxt_strb = 3'h3;
          if (!is_wr_ff) begin
            nxt_rd = P.dpin;
          end
        end
      end
      pe_pkg::PE_H_HOLD: begin
        nxt_cnt = cnt_ff - 8'h01;
        if (cnt_ff == 8'h00) begin
          nxt_st   = pe_pkg::PE_H_IDLE;
          nxt_strb = 3'h7;
        end
      end
      default: begin
        nxt_st = pe_pkg::PE_H_IDLE;
      end
    endcase
    if (!aw_free_ff && !w_free_ff && !bvalid_ff) begin
      nxt_aw_free = 1'b1;
      nxt_w_free  = 1'b1;
      nxt_bvalid  = 1'b1;
      nxt_bresp   = cmd_hit ? `PE_RESP_OKAY : `PE_RESP_SLVERR;
      if (cmd_hit && st_ff == pe_pkg::PE_H_IDLE && wdata_ff[1:0] != 2'h0) begin
        nxt_st    = pe_pkg::PE_H_SETUP;
        nxt_cnt   = 8'(SETUP_CYC - 1);
        nxt_is_wr = wdata_ff[1];
        nxt_wd    = wdata_ff[15:8];
        nxt_strb  = 3'h3;
      end
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_ff      <= pe_pkg::PE_H_IDLE;
      cnt_ff     <= 8'h00;
      wd_ff      <= 8'h00;
      rd_ff      <= 8'h00;
      is_wr_ff   <= 1'b0;
      strb_ff    <= 3'h7;
      aw_free_ff <= 1'b1;
      w_free_ff  <= 1'b1;
      bvalid_ff  <= 1'b0;
      ar_free_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      awaddr_ff  <= '0;
      wdata_ff   <= 16'h0000;
      rdata_ff   <= 16'h0000;
      bresp_ff   <= `PE_RESP_OKAY;
      rresp_ff   <= `PE_RESP_OKAY;
    end else if (CE) begin
      st_ff      <= nxt_st;
      cnt_ff     <= nxt_cnt;
      wd_ff      <= nxt_wd;
      rd_ff      <= nxt_rd;
      is_wr_ff   <= nxt_is_wr;
      strb_ff    <= nxt_strb;
      aw_free_ff <= nxt_aw_free;
      w_free_ff  <= nxt_w_free;
      bvalid_ff  <= nxt_bvalid;
      ar_free_ff <= nxt_ar_free;
      rvalid_ff  <= nxt_rvalid;
      awaddr_ff  <= nxt_awaddr;
      wdata_ff   <= nxt_wdata;
      rdata_ff   <= nxt_rdata;
      bresp_ff   <= nxt_bresp;
      rresp_ff   <= nxt_rresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strobes drive pins 2:0 only while a transfer is open
  assign P.host_out    = {5'h1F, strb_ff};
  assign P.host_oe_n   = {5'h1F, {3{st_ff == pe_pkg::PE_H_IDLE}}};
  assign P.host_d_out  = wd_ff;
  assign P.host_d_oe_n = {8{!(is_wr_ff && st_ff != pe_pkg::PE_H_IDLE)}};
  assign AWREADY       = aw_free_ff;
  assign WREADY        = w_free_ff;
  assign BVALID        = bvalid_ff;
  assign BRESP         = bresp_ff;
  assign ARREADY       = ar_free_ff;
  assign RVALID        = rvalid_ff;
  assign RRESP         = rresp_ff;
  assign RDATA         = {16'h0000, rdata_ff};
endmodule

// ### tb/pe_assertions.sv
// Purpose: Pin-level checks on the port link
// Assumes: Host built with STROBE_CYC 4, SETUP_CYC 2
// Notes:   Watches the shared pins only
`timescale 1ns/1ps
module pe_assertions (
  input logic       CLK,
  input logic       NRST,
  input logic [7:0] dev_oe_n,
  input logic [7:0] dev_d_oe_n,
  input logic [7:0] host_out,
  input logic [7:0] host_oe_n,
  input logic [7:0] host_d_out,
  input logic [7:0] host_d_oe_n
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  wire rs = ~host_oe_n[0] & ~host_out[0];
  wire ws = ~host_oe_n[1] & ~host_out[1];
  wire cs = ~host_oe_n[2] & ~host_out[2];
  wire st = rs | ws;
  ////////////////////////////////////////////////////////////////////////////
  a_rd_window: assert property (
    (dev_oe_n[2:0] == 3'h7 && dev_d_oe_n != 8'hFF) |-> $past(rs & cs, 2))
    else $error("data driven without read");
  a_rd_answer: assert property (
    $rose(rs) |-> ##1 dev_d_oe_n == 8'hFF ##1 dev_d_oe_n == 8'h00)
    else $error("read data late or early");
  a_no_clash: assert property (
    host_d_oe_n != 8'hFF |-> dev_d_oe_n == 8'hFF) else $error("data clash");
  a_strobe_len: assert property (
    $rose(st) |-> st [*4] ##1 !st) else $error("strobe length");
  a_cs_setup: assert property (
    $rose(st) |-> cs && $past(cs, 2)) else $error("strobe before select");
  a_cs_hold: assert property (
    $fell(st) |-> cs [*2] ##1 !cs) else $error("select hold");
  a_reset_idle: assert property (
    $rose(NRST) |-> dev_oe_n == 8'hFF) else $error("pins driven at reset");
  a_ctl_inputs: assert property (
    host_oe_n[2:0] != 3'h7 |-> dev_oe_n[2:0] == 3'h7) else $error("strobe pin fight");
  a_wr_stable: assert property (
    ws && $past(ws) |-> $stable(host_d_out)) else $error("write data moved");
  c_read: cover property ($rose(rs));
  c_write: cover property ($rose(ws));
  c_bus: cover property (dev_oe_n == 8'h00);
endmodule

// ### tb/pe_tb.sv
// Purpose: Self-checking bench for the port and its host
// Assumes: One AXI transfer at a time on either end
// Notes:   Short strobe counts keep the run brief
`timescale 1ns/1ps
`include "pe_defs.svh"
module pe_tb;
  logic        clk;
  logic        nrst = 1'b0, orst = 1'b0, lpkg = 1'b0, csel = 1'b1;
  logic        eoe = 1'b0, co = 1'b0, coe = 1'b0, bry = 1'b0, rry = 1'b0;
  logic [1:0]  mode = 2'h0;
  logic [7:0]  ehi = 8'h00, elo = 8'h00, aw = 8'h00, ar = 8'h00, ehin, elin;
  logic [31:0] wd = 32'h0;
  logic [3:0]  ws = 4'hF;
  logic [1:0]  awv = 2'h0, wv = 2'h0, arv = 2'h0, awr, wr, bv, arr, rv;
  logic [1:0]  br [2];
  logic [1:0]  rr [2];
  logic [31:0] rd [2];
  logic        cin;
  int          error_cnt = 0, total_checks = 0;
  pe_pin_if pif ();
  pe_dev i_pe_dev (.CLK(clk), .NRST(nrst), .CE(1'b1), .OTHER_RST(orst), .MODE(mode),
    .LARGE_PKG(lpkg), .CAP_PIN_SEL(csel), .EBUS_OUT_HI(ehi), .EBUS_OUT_LO(elo),
    .EBUS_OE(eoe), .EBUS_IN_HI(ehin), .EBUS_IN_LO(elin), .CCP_OUT(co), .CCP_OE(coe),
    .CCP_IN(cin), .AWADDR(aw), .AWVALID(awv[0]), .AWREADY(awr[0]), .WDATA(wd),
    .WSTRB(ws), .WVALID(wv[0]), .WREADY(wr[0]), .BRESP(br[0]), .BVALID(bv[0]),
    .BREADY(bry), .ARADDR(ar), .ARVALID(arv[0]), .ARREADY(arr[0]), .RDATA(rd[0]),
    .RRESP(rr[0]), .RVALID(rv[0]), .RREADY(rry), .P(pif.dev));
  pe_host #(.STROBE_CYC(4), .SETUP_CYC(2)) i_pe_host (.CLK(clk), .NRST(nrst), .CE(1'b1),
    .AWADDR(aw), .AWVALID(awv[1]), .AWREADY(awr[1]), .WDATA(wd), .WSTRB(ws),
    .WVALID(wv[1]), .WREADY(wr[1]), .BRESP(br[1]), .BVALID(bv[1]), .BREADY(bry),
    .ARADDR(ar), .ARVALID(arv[1]), .ARREADY(arr[1]), .RDATA(rd[1]), .RRESP(rr[1]),
    .RVALID(rv[1]), .RREADY(rry), .P(pif.host));
  pe_assertions i_chk (.CLK(clk), .NRST(nrst), .dev_oe_n(pif.dev_oe_n),
    .dev_d_oe_n(pif.dev_d_oe_n), .host_out(pif.host_out), .host_oe_n(pif.host_oe_n),
    .host_d_out(pif.host_d_out), .host_d_oe_n(pif.host_d_oe_n));
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // Valid held until its own ready; response waited on without a cycle bound
  task automatic ax(input int t, input bit w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q, output logic [1:0] r);
    bit ka, kw, kr;
    ka = !w;
    kw = !w;
    kr = w;
    @(posedge clk);
    aw <= a;
    ar <= a;
    wd <= d;
    awv[t] <= w;
    wv[t] <= w;
    arv[t] <= !w;
    bry <= w;
    rry <= !w;
    while (!(ka && kw && kr)) begin
      @(posedge clk);
      if (awr[t]) awv[t] <= 1'b0;
      if (wr[t]) wv[t] <= 1'b0;
      if (arr[t]) arv[t] <= 1'b0;
      ka = ka | awr[t];
      kw = kw | wr[t];
      kr = kr | arr[t];
    end
    while ((w ? bv[t] : rv[t]) !== 1'b1) @(posedge clk);
    q = rd[t];
    r = w ? br[t] : rr[t];
    bry <= 1'b0;
    rry <= 1'b0;
  endtask
  task automatic wreg(input int t, input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic [1:0]  r;
    ax(t, 1'b1, a, d, q, r);
  endtask
  task automatic rchk(input int t, input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] q;
    logic [1:0]  r;
    ax(t, 1'b0, a, 32'h0, q, r);
    chk(n, e, q);
  endtask
  task automatic hwait(output logic [31:0] q);
    logic [1:0] r;
    q = 32'h1;
    while (q[0] !== 1'b0) ax(1, 1'b0, `PE_HOFS_STAT, 32'h0, q, r);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rchk(0, `PE_OFS_DIR, 32'hFF, "dir");
    rchk(0, `PE_OFS_SPC, 32'h00, "spc");
    rchk(0, `PE_OFS_MEM, 32'h00, "mem");
    chk("oe", 32'hFF, pif.dev_oe_n);
  endtask
  task automatic t_gpio;
    logic [31:0] q;
    logic [1:0]  r;
    wreg(0, `PE_OFS_PIN, 32'hA5);
    wreg(0, `PE_OFS_DIR, 32'h0F);
    repeat (2) @(posedge clk);
    chk("oe", 32'h0F, pif.dev_oe_n);
    chk("pin", 32'hAF, pif.pin);
    rchk(0, `PE_OFS_PIN, 32'hAF, "pin rd");
    rchk(0, `PE_OFS_LAT, 32'hA5, "lat");
    ws <= 4'h0;
    wreg(0, `PE_OFS_LAT, 32'h3C);
    ws <= 4'hF;
    rchk(0, `PE_OFS_LAT, 32'hA5, "no strobe");
    ax(0, 1'b1, 8'h18, 32'h0, q, r);
    chk("bresp", `PE_RESP_SLVERR, r);
    ax(0, 1'b0, 8'h18, 32'h0, q, r);
    chk("rresp", `PE_RESP_SLVERR, r);
  endtask
  task automatic t_bus;
    lpkg <= 1'b1;
    mode <= 2'h1;
    ehi <= 8'h3C;
    elo <= 8'hC3;
    eoe <= 1'b1;
    repeat (3) @(posedge clk);
    chk("bus oe", 32'h00, pif.dev_oe_n);
    chk("bus hi", 32'h3C, pif.pin);
    chk("bus lo", 32'hC3, pif.dpin);
    chk("bus in", 32'h3C, ehin);
    chk("bus in lo", 32'hC3, elin);
    wreg(0, `PE_OFS_MEM, 32'hFF);
    rchk(0, `PE_OFS_MEM, 32'hB3, "mem");
    repeat (2) @(posedge clk);
    chk("io oe", 32'h0F, pif.dev_oe_n);
    wreg(0, `PE_OFS_MEM, 32'h00);
    mode <= 2'h0;
    eoe <= 1'b0;
  endtask
  task automatic t_ccp;
    csel <= 1'b0;
    coe <= 1'b1;
    repeat (3) @(posedge clk);
    chk("ccp pin", 32'h0, pif.pin[7]);
    chk("ccp in", 32'h0, cin);
    csel <= 1'b1;
    repeat (3) @(posedge clk);
    chk("ccp off", 32'h1, pif.pin[7]);
  endtask
  task automatic t_orst;
    orst <= 1'b1;
    @(posedge clk);
    orst <= 1'b0;
    rchk(0, `PE_OFS_DIR, 32'hFF, "dir");
    rchk(0, `PE_OFS_LAT, 32'hA5, "lat kept");
  endtask
  task automatic t_psp;
    logic [31:0] q;
    logic [1:0]  r;
    wreg(0, `PE_OFS_DIR, 32'hFF);
    wreg(0, `PE_OFS_SPC, 32'h10);
    wreg(0, `PE_OFS_SPD, 32'h5A);
    rchk(0, `PE_OFS_SPC, 32'h50, "obf");
    wreg(1, `PE_HOFS_CMD, 32'hC302);
    hwait(q);
    rchk(0, `PE_OFS_SPC, 32'hD0, "ibf");
    rchk(0, `PE_OFS_SPD, 32'hC3, "spd");
    wreg(1, `PE_HOFS_CMD, 32'h1);
    hwait(q);
    chk("host rd", 32'h5A, q[15:8]);
    rchk(0, `PE_OFS_SPC, 32'h10, "flags");
    repeat (2) begin
      wreg(1, `PE_HOFS_CMD, 32'h7702);
      hwait(q);
    end
    rchk(0, `PE_OFS_SPC, 32'hB0, "ibov");
    wreg(0, `PE_OFS_SPC, 32'h10);
    rchk(0, `PE_OFS_SPC, 32'h90, "ibov clr");
    ax(1, 1'b0, 8'h08, 32'h0, q, r);
    chk("host err", `PE_RESP_SLVERR, r);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    test_done;
  end
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_gpio;
    t_bus;
    t_ccp;
    t_orst;
    t_psp;
    test_done;
  end
endmodule
